// [bench/logic_cell_tb.sv]
// bench for the logic cell: bus access, lut modes, counters, clear/preset and the emulated bus
// assumes one wait state per access and cell inputs handed over one edge late by the neighbour
`timescale 1ns/100ps
module logic_cell_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic_cell_pkg::cell_in_t want = 9'h001;
  logic_cell_pkg::cell_in_t cellIn;
  logic_cell_pkg::cell_in_t v;
  logic_cell_pkg::cell_in_t prev;
  logic_cell_pkg::cell_out_t cellOut;
  logic_cell_pkg::cfg_t cfg;
  logic [3:0] triEn = 4'h0;
  logic [3:0] triData = 4'h0;
  logic triBus;
  logic [31:0] rd;
  logic [31:0] r;
  logic [15:0] mask;
  logic [31:0] seed = 32'h56C3E3C5;
  logic mreg;
  logic e;
  logic c;
  logic o;
  logic ca;
  int errCount = 0;
  int testsRun = 0;
  // entry: clear/preset mode, line a, line b, data three, chip reset (low active), expected register
  localparam logic [10:0] AT [13] = '{{6'h01, 5'b10110}, {6'h01, 5'b01110}, {6'h02, 5'b10111},
    {6'h04, 5'b10111}, {6'h04, 5'b01110}, {6'h08, 5'b10010}, {6'h08, 5'b10111}, {6'h08, 5'b11110},
    {6'h10, 5'b01011}, {6'h20, 5'b10111}, {6'h20, 5'b10010}, {6'h04, 5'b10100}, {6'h10, 5'b00001}};

  always #10 clk = ~clk;

  neighbour_cells nb (.clk(clk), .rst(rst), .want(want), .cellIn(cellIn));
  logic_cell dut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .cellIn(cellIn), .cellOut(cellOut), .triEn(triEn), .triData(triData), .triBus(triBus));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic lut();
    logic [3:0] i;
    i = {v.dataIn[3], cfg.sel3Carry ? v.carryIn : v.dataIn[2], v.dataIn[1:0]};
    if (cfg.mode == logic_cell_pkg::MODE_ARITH) begin
      i = {1'b0, v.carryIn, v.dataIn[1:0]};
    end
    return mask[i];
  endfunction : lut

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // no local limit on the wait: only the watchdog ends a hung access
  task automatic bus(input logic wr, input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    byteenable <= be;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    check(waitrequest, 32'h0, "no answer");
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  // two edges so the register has captured the old inputs and the new ones are settled
  task automatic apply();
    @(posedge clk);
    want <= v;
    @(posedge clk);
    @(negedge clk);
  endtask : apply

  task automatic endSim();
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : endSim

  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    endSim();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, logic_cell_pkg::CFG_OFS, 4'hF, 32'h0);
    check(rd, {14'h0, logic_cell_pkg::CFG_RST}, "cfg reset");
    bus(1'b0, logic_cell_pkg::MASK_OFS, 4'hF, 32'h0);
    check(rd, 32'h0, "mask reset");
    bus(1'b1, 4'hC, 4'hF, 32'hFFFF_FFFF);
    bus(1'b0, 4'hC, 4'hF, 32'h0);
    check(rd, 32'h0, "unmapped");
    bus(1'b1, logic_cell_pkg::MASK_OFS, 4'h1, 32'hFFFF_FFFF);
    bus(1'b0, logic_cell_pkg::MASK_OFS, 4'hF, 32'h0);
    check(rd, 32'h0000_00FF, "byte lane");
    for (int k = 0; k < 60; k++) begin
      r = rnd();
      mask = r[15:0];
      cfg = logic_cell_pkg::CFG_RST;
      cfg.mode = k[0] ? logic_cell_pkg::MODE_ARITH : logic_cell_pkg::MODE_NORMAL;
      {cfg.sel3Carry, cfg.cascEn, cfg.cascOr} = r[18:16];
      bus(1'b1, logic_cell_pkg::MASK_OFS, 4'hF, {16'h0, mask});
      bus(1'b1, logic_cell_pkg::CFG_OFS, 4'hF, {14'h0, cfg});
      r = rnd();
      v = r[8:0];
      apply();
      e = lut();
      c = cfg.cascOr ? (e | v.cascadeIn) : (e & v.cascadeIn);
      // with cascEn set the cell output is the table result after the cascade join, as the chain needs it
      o = cfg.cascEn ? c : e;
      ca = k[0] ? mask[{1'b1, v.carryIn, v.dataIn[1:0]}] : v.carryIn;
      check(cellOut.localOut, o, "lut");
      check(cellOut.cascadeOut, cfg.cascEn ? c : e, "cascade");
      check(cellOut.carryOut, k[0] ? mask[{1'b1, v.carryIn, v.dataIn[1:0]}] : v.carryIn, "carry");
      bus(1'b0, logic_cell_pkg::STAT_OFS, 4'hF, 32'h0);
      check({rd[4:2], rd[0]}, {1'b1, o, ca, o}, "status");
    end
    cfg = logic_cell_pkg::CFG_RST;
    cfg.packD4 = 1'b1;
    cfg.ceFromD1 = 1'b1;
    bus(1'b1, logic_cell_pkg::CFG_OFS, 4'hF, {14'h0, cfg});
    v = 9'h021;
    apply();
    apply();
    mreg = 1'b0;
    prev = v;
    for (int k = 0; k < 40; k++) begin
      {cfg.localReg, cfg.globalReg} = k[0] ? 2'b10 : 2'b01;
      bus(1'b1, logic_cell_pkg::CFG_OFS, 4'hF, {14'h0, cfg});
      r = rnd();
      v = {r[8:3], 3'b001};
      apply();
      if (prev.dataIn[0]) begin
        mreg = prev.dataIn[3];
      end
      e = lut();
      check(cellOut.regQ, mreg, "packed reg");
      check(cellOut.localOut, k[0] ? mreg : e, "local");
      check(cellOut.globalOut, k[0] ? e : mreg, "global");
      prev = v;
    end
    // all-ones mask: the count path always offers a one, so load and clear stand out
    mask = 16'hFFFF;
    bus(1'b1, logic_cell_pkg::MASK_OFS, 4'hF, {16'h0, mask});
    for (int k = 0; k < 16; k++) begin
      cfg = logic_cell_pkg::CFG_RST;
      cfg.mode = k[3] ? logic_cell_pkg::MODE_CLRCNT : logic_cell_pkg::MODE_UPDOWN;
      bus(1'b1, logic_cell_pkg::CFG_OFS, 4'hF, {14'h0, cfg});
      v = {k[1], k[0], 2'b10, 1'b0, k[2], 3'b001};
      apply();
      apply();
      check(cellOut.regQ, (k[3] & k[2]) ? 1'b0 : (k[1] ? k[0] : 1'b1), "counter");
    end
    cfg = logic_cell_pkg::CFG_RST;
    cfg.packD4 = 1'b1;
    for (int k = 0; k < 13; k++) begin
      cfg.cpMode = logic_cell_pkg::cp_mode_t'(AT[k][10:5]);
      bus(1'b1, logic_cell_pkg::CFG_OFS, 4'hF, {14'h0, cfg});
      v = {~AT[k][0], AT[k][2], 2'b00, 2'b00, AT[k][4:3], AT[k][1]};
      apply();
      check(cellOut.regQ, AT[k][0], "clear preset");
      // the same compare
    end
    for (int k = 0; k < 256; k++) begin
      @(posedge clk);
      {triEn, triData} <= k[7:0];
      @(negedge clk);
      e = ($countones(triEn) == 0) ? 1'b1 : ($countones(triEn) > 1) ? 1'b0 : |(triEn & triData);
      check(triBus, e, "emulated bus");
    end
    endSim();
  end
endmodule : logic_cell_tb

// [bench/neighbour_cells.sv]
// the previous cell of the chain and the cluster control lines, as seen by one logic cell
// assumes the bench asks for levels; they reach the cell just after the next clock edge
`timescale 1ns/100ps
module neighbour_cells (
  input wire logic clk,
  input wire logic rst,
  input wire logic_cell_pkg::cell_in_t want,
  output logic_cell_pkg::cell_in_t cellIn
);
  // registered like a real neighbour, so inputs never move in the same step as the cell samples them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cellIn <= 9'h001;
    end else begin
      cellIn <= want;
    end
  end
endmodule : neighbour_cells

// [design/logic_cell.sv]
// one programmable logic cell with its configuration registers
// assumes an Avalon-MM master on clk and cell inputs synchronous to clk
// Notes on behaviour
// - four modes: normal, arithmetic, up/down counter, clearable counter
// - four data inputs, feedback, carry-in, cascade-in steered per mode
// - register has a clock enable in every mode, optionally from data input one
// - normal mode lut takes data inputs, carry-in or data three selectable
// - normal mode lut output combines with cascade-in into cascade-out
// - cascade combine is AND, or OR through inverted inputs and output
// - packing in normal mode: data four feeds the register, lut computes its own function
// - packed register keeps controls; register and lut outputs swap freely
// - arithmetic mode: sum lut and carry lut of carry-in and two inputs
// - up/down counter: count enable, clock enable, direction, load
// - two-way mux picks count or load data; async load via clear/preset
// - clearable counter: cascade-in is a sync clear forcing zero
// - emulated bus: several drivers give low, no driver gives high
// - clear and preset are active low, unused ones stay high
// - six clear/preset arrangements, all acting at once
// - enabled chip-wide reset clears the register over everything
// - clear mode: either cluster line clears, preset inactive
// - preset by loading a one from data three on line a
// - clear plus preset: line a loads a one, line b clears
// - load modes: line a copies data three at once
// - load with clear: line b reaches only the clear
// - load with preset: register inverted, b presets, a loads data three
`timescale 1ns/100ps
module logic_cell #(
  parameter int TRI_DRIVERS = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic_cell_pkg::cell_in_t cellIn,
  output logic_cell_pkg::cell_out_t cellOut,
  input wire logic [TRI_DRIVERS - 1:0] triEn,
  input wire logic [TRI_DRIVERS - 1:0] triData,
  output logic triBus
);

  logic_cell_pkg::state_t state_ff;
  logic_cell_pkg::state_t nxt_state;
  logic_cell_pkg::cfg_t cfg;
  logic [3:0] d;
  logic [3:0] lut4Sel;
  logic [2:0] idx3;
  logic lut4Y;
  logic lowY;
  logic highY;
  logic clrN;
  logic preN;
  logic invStore;
  logic qStored;
  logic cellQ;
  logic ce;
  logic combOut;
  logic carryOutV;
  logic cascOutV;
  logic dIn;
  logic cnt;
  logic ld;
  logic req;
  logic [31:0] statWord;
  logic [31:0] merged;

  // byte lanes of a write land on the old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8 * i +: 8] = wd[8 * i +: 8];
      end
    end
    return r;
  endfunction : merge

  assign cfg = state_ff.cfg;
  assign d = cellIn.dataIn;

  // selectors of the table inputs per mode
  assign lut4Sel = {d[3], cfg.sel3Carry ? cellIn.carryIn : d[2], d[1], d[0]};
  always_comb begin
    case (cfg.mode)
      logic_cell_pkg::MODE_UPDOWN: idx3 = {cellIn.cascadeIn, cellIn.carryIn, cellQ};
      logic_cell_pkg::MODE_CLRCNT: idx3 = {d[1], cellIn.carryIn, cellQ};
      default: idx3 = {cellIn.carryIn, d[1], d[0]};
    endcase
  end

  lut_unit #(.INPUTS(4)) u_lut4 (
    .mask(state_ff.lutMask),
    .sel(lut4Sel),
    .y(lut4Y)
  );
  lut_unit #(.INPUTS(3)) u_lut_low (
    .mask(state_ff.lutMask[7:0]),
    .sel(idx3),
    .y(lowY)
  );
  lut_unit #(.INPUTS(3)) u_lut_high (
    .mask(state_ff.lutMask[15:8]),
    .sel(idx3),
    .y(highY)
  );
  tri_emul #(.DRIVERS(TRI_DRIVERS)) u_tri (
    .en(triEn),
    .data(triData),
    .bus(triBus)
  );

  // clear and preset are active low; the asynchronous effect is shown at once through qStored
  always_comb begin
    clrN = 1'b1;
    preN = 1'b1;
    invStore = 1'b0;
    case (cfg.cpMode)
      logic_cell_pkg::CP_CLEAR: begin
        clrN = ~(cellIn.ctrlA | cellIn.ctrlB);
      end
      logic_cell_pkg::CP_PRESET: begin
        preN = ~(cellIn.ctrlA & d[2]);
        clrN = ~(cellIn.ctrlA & ~d[2]);
      end
      logic_cell_pkg::CP_CLRPRE: begin
        preN = ~cellIn.ctrlA;
        clrN = ~cellIn.ctrlB;
      end
      logic_cell_pkg::CP_LOADCLR: begin
        preN = ~(cellIn.ctrlA & d[2]);
        clrN = ~((cellIn.ctrlA & ~d[2]) | cellIn.ctrlB);
      end
      logic_cell_pkg::CP_LOADPRE: begin
        invStore = 1'b1;
        preN = ~(cellIn.ctrlA & ~d[2]);
        clrN = ~((cellIn.ctrlA & d[2]) | cellIn.ctrlB);
      end
      default: begin
        preN = ~(cellIn.ctrlA & d[2]);
        clrN = ~(cellIn.ctrlA & ~d[2]);
      end
    endcase
    if (!clrN) begin
      preN = 1'b1;
    end
    if (cfg.chipRstEn && !cellIn.chipRstN) begin
      clrN = 1'b0;
      preN = 1'b1;
    end
    qStored = !clrN ? 1'b0 : (!preN ? 1'b1 : state_ff.cellReg);
    cellQ = qStored ^ invStore;
  end

  // datapath of the four modes and the register bus
  always_comb begin
    nxt_state = state_ff;
    ce = cfg.ceFromD1 ? d[0] : 1'b1;
    cnt = lowY;
    ld = lowY;
    case (cfg.mode)
      logic_cell_pkg::MODE_ARITH: begin
        combOut = lowY;
        carryOutV = highY;
      end
      logic_cell_pkg::MODE_UPDOWN: begin
        combOut = lowY;
        carryOutV = highY;
        cnt = d[1] ? lowY : cellQ;
        ld = d[3] ? d[2] : cnt;
      end
      logic_cell_pkg::MODE_CLRCNT: begin
        combOut = lowY;
        carryOutV = highY;
        ld = (d[3] ? d[2] : cnt) & ~cellIn.cascadeIn;
      end
      default: begin
        combOut = lut4Y;
        carryOutV = cellIn.carryIn;
      end
    endcase
    // cascade joins the table output of normal and arithmetic modes
    cascOutV = 1'b1;
    if (cfg.mode != logic_cell_pkg::MODE_UPDOWN && cfg.mode != logic_cell_pkg::MODE_CLRCNT) begin
      if (cfg.cascEn) begin
        if (cfg.cascOr) begin
          combOut = ~(~combOut & ~cellIn.cascadeIn);
        end else begin
          combOut = combOut & cellIn.cascadeIn;
        end
      end
      cascOutV = combOut;
      ld = combOut;
    end
    dIn = ld;
    if (cfg.mode == logic_cell_pkg::MODE_NORMAL && cfg.packD4) begin
      dIn = d[3];
    end
    if (!clrN || !preN) begin
      nxt_state.cellReg = qStored;
    end else if (ce) begin
      nxt_state.cellReg = dIn ^ invStore;
    end

    statWord = 32'h0000_0000;
    statWord[logic_cell_pkg::ST_COMB] = combOut;
    statWord[logic_cell_pkg::ST_REGQ] = cellQ;
    statWord[logic_cell_pkg::ST_CARRY] = carryOutV;
    statWord[logic_cell_pkg::ST_CASC] = cascOutV;
    statWord[logic_cell_pkg::ST_TRI] = triBus;

    // one wait cycle: read data is latched while waitrequest is high
    req = read | write;
    waitrequest = req & ~state_ff.ack;
    nxt_state.ack = req & ~state_ff.ack;
    merged = 32'h0000_0000;
    if (read && !state_ff.ack) begin
      case (address)
        logic_cell_pkg::CFG_OFS: nxt_state.rdata = {14'h0000, cfg};
        logic_cell_pkg::MASK_OFS: nxt_state.rdata = {16'h0000, state_ff.lutMask};
        logic_cell_pkg::STAT_OFS: nxt_state.rdata = statWord;
        default: nxt_state.rdata = 32'h0000_0000;
      endcase
    end
    if (write && state_ff.ack) begin
      case (address)
        logic_cell_pkg::CFG_OFS: begin
          merged = merge({14'h0000, cfg}, writedata, byteenable);
          nxt_state.cfg = logic_cell_pkg::cfg_t'(merged[17:0]);
        end
        logic_cell_pkg::MASK_OFS: begin
          merged = merge({16'h0000, state_ff.lutMask}, writedata, byteenable);
          nxt_state.lutMask = merged[15:0];
        end
        default: merged = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= logic_cell_pkg::STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign readdata = state_ff.rdata;
  assign cellOut.localOut = cfg.localReg ? cellQ : combOut;
  assign cellOut.globalOut = cfg.globalReg ? cellQ : combOut;
  assign cellOut.carryOut = carryOutV;
  assign cellOut.cascadeOut = cascOutV;
  assign cellOut.regQ = cellQ;

  clear_any_a: assert property (
    @(posedge clk) disable iff (rst)
    (cfg.cpMode == logic_cell_pkg::CP_CLEAR && (cellIn.ctrlA || cellIn.ctrlB)) |-> !cellOut.regQ
  ) else $error("clear line did not clear the cell");

  clear_wins_a: assert property (
    @(posedge clk) disable iff (rst)
    (cfg.cpMode == logic_cell_pkg::CP_LOADCLR && cellIn.ctrlB) |-> !cellOut.regQ
  ) else $error("load overrode a clear");

  load_copy_a: assert property (
    @(posedge clk) disable iff (rst)
    (cfg.cpMode == logic_cell_pkg::CP_LOAD && cellIn.ctrlA && !(cfg.chipRstEn && !cellIn.chipRstN))
      |-> (cellOut.regQ == d[2]) ##1 (state_ff.cellReg == $past(d[2]))
  ) else $error("load did not copy data three");

  inv_preset_a: assert property (
    @(posedge clk) disable iff (rst)
    (cfg.cpMode == logic_cell_pkg::CP_LOADPRE && cellIn.ctrlB && !cellIn.ctrlA) |-> cellOut.regQ
  ) else $error("inverted register not preset");

  chip_reset_a: assert property (
    @(posedge clk) disable iff (rst)
    (cfg.chipRstEn && !cellIn.chipRstN) |=> (state_ff.cellReg == 1'b0)
  ) else $error("chip reset did not clear the register");

  hold_ce_a: assert property (
    @(posedge clk) disable iff (rst)
    (cfg.ceFromD1 && !d[0] && clrN && preN) |=> $stable(state_ff.cellReg)
  ) else $error("register moved without clock enable");

  sync_clear_a: assert property (
    @(posedge clk) disable iff (rst)
    (cfg.mode == logic_cell_pkg::MODE_CLRCNT && ce && cellIn.cascadeIn && clrN && preN)
      |=> (state_ff.cellReg == $past(invStore))
  ) else $error("synchronous clear did not zero the count");

  cascade_and_a: assert property (
    @(posedge clk) disable iff (rst)
    (cfg.mode == logic_cell_pkg::MODE_NORMAL && cfg.cascEn && !cfg.cascOr && !cellIn.cascadeIn)
      |-> !cellOut.cascadeOut
  ) else $error("cascade AND passed a one");

  tri_float_a: assert property (
    @(posedge clk) disable iff (rst)
    (triEn == '0) |-> triBus ##0 ($countones(triEn) < 2 || !triBus)
  ) else $error("floating bus not high");

  tri_clash_a: assert property (
    @(posedge clk) disable iff (rst)
    ($countones(triEn) > 1) |-> !triBus
  ) else $error("contending bus not low");

  preset_load_a: assert property (
    @(posedge clk) disable iff (rst)
    (cfg.cpMode == logic_cell_pkg::CP_PRESET && cellIn.ctrlA && d[2] && !(cfg.chipRstEn && !cellIn.chipRstN))
      |-> cellOut.regQ
  ) else $error("preset line did not load a one");

  clear_preset_a: assert property (
    @(posedge clk) disable iff (rst)
    (cfg.cpMode == logic_cell_pkg::CP_CLRPRE && cellIn.ctrlA && !cellIn.ctrlB && !(cfg.chipRstEn && !cellIn.chipRstN))
      |-> cellOut.regQ
  ) else $error("line a did not preset the cell");

  // an inverted register reads back as one while chip reset holds its store at zero
  chip_over_a: assert property (
    @(posedge clk) disable iff (rst)
    (cfg.chipRstEn && !cellIn.chipRstN) |-> (cellOut.regQ == (cfg.cpMode == logic_cell_pkg::CP_LOADPRE))
  ) else $error("chip reset did not override the controls");

  load_mux_a: assert property (
    @(posedge clk) disable iff (rst)
    (cfg.mode == logic_cell_pkg::MODE_UPDOWN && cfg.cpMode != logic_cell_pkg::CP_LOADPRE && d[3] && ce && clrN && preN)
      |=> (state_ff.cellReg == $past(d[2]))
  ) else $error("synchronous load did not take data three");

  arith_carry_a: assert property (
    @(posedge clk) disable iff (rst)
    (cfg.mode == logic_cell_pkg::MODE_ARITH) |-> (cellOut.carryOut == state_ff.lutMask[{1'b1, cellIn.carryIn, d[1:0]}])
  ) else $error("carry table half not on carry out");

  bus_wait_a: assert property (
    @(posedge clk) disable iff (rst)
    (req && waitrequest) |=> !waitrequest
  ) else $error("bus answer took more than one wait cycle");

endmodule : logic_cell

// [design/logic_cell_pkg.sv]
// types, offsets and reset values shared by the logic cell files
// assumes an Avalon-MM master with 4-bit byte addresses and 32-bit data
package logic_cell_pkg;

  typedef enum logic [3:0] {
    MODE_NORMAL = 4'h1,
    MODE_ARITH = 4'h2,
    MODE_UPDOWN = 4'h4,
    MODE_CLRCNT = 4'h8
  } mode_t;

  typedef enum logic [5:0] {
    CP_CLEAR = 6'h01,
    CP_PRESET = 6'h02,
    CP_CLRPRE = 6'h04,
    CP_LOADCLR = 6'h08,
    CP_LOADPRE = 6'h10,
    CP_LOAD = 6'h20
  } cp_mode_t;

  // configuration word, bit 17 down to bit 0
  typedef struct packed {
    mode_t mode;
    cp_mode_t cpMode;
    logic sel3Carry;
    logic packD4;
    logic ceFromD1;
    logic cascEn;
    logic cascOr;
    logic chipRstEn;
    logic localReg;
    logic globalReg;
  } cfg_t;

  typedef struct packed {
    logic [3:0] dataIn;
    logic carryIn;
    logic cascadeIn;
    logic ctrlA;
    logic ctrlB;
    logic chipRstN;
  } cell_in_t;

  typedef struct packed {
    logic localOut;
    logic globalOut;
    logic carryOut;
    logic cascadeOut;
    logic regQ;
  } cell_out_t;

  typedef struct packed {
    cfg_t cfg;
    logic [15:0] lutMask;
    logic cellReg;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  localparam logic [3:0] CFG_OFS = 4'h0;
  localparam logic [3:0] MASK_OFS = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;

  localparam int ST_COMB = 0;
  localparam int ST_REGQ = 1;
  localparam int ST_CARRY = 2;
  localparam int ST_CASC = 3;
  localparam int ST_TRI = 4;

  localparam cfg_t CFG_RST = '{mode: MODE_NORMAL, cpMode: CP_CLEAR, sel3Carry: 1'b0, packD4: 1'b0,
    ceFromD1: 1'b0, cascEn: 1'b0, cascOr: 1'b0, chipRstEn: 1'b1, localReg: 1'b0, globalReg: 1'b1};
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam state_t STATE_RST = '{cfg: CFG_RST, lutMask: MASK_RST, cellReg: 1'b0, ack: 1'b0,
    rdata: 32'h0000_0000};

endpackage : logic_cell_pkg

// [design/lut_unit.sv]
// lookup table of configurable input count, mask bit picked by the inputs
// assumes mask and select are stable combinational values
`timescale 1ns/100ps
module lut_unit #(
  parameter int INPUTS = 4
) (
  input wire logic [(1 << INPUTS) - 1:0] mask,
  input wire logic [INPUTS - 1:0] sel,
  output logic y
);
  assign y = mask[sel];
endmodule : lut_unit

// [design/tri_emul.sv]
// internal bus built as a multiplexer in place of tri-state drivers
// assumes enables are active high, one bit per driver
`timescale 1ns/100ps
module tri_emul #(
  parameter int DRIVERS = 4
) (
  input wire logic [DRIVERS - 1:0] en,
  input wire logic [DRIVERS - 1:0] data,
  output logic bus
);
  // contention resolves low, a floating bus resolves high
  always_comb begin
    if (en == '0) begin
      bus = 1'b1;
    end else if ($onehot(en)) begin
      bus = |(en & data);
    end else begin
      bus = 1'b0;
    end
  end
endmodule : tri_emul
